//--- nvmpw_ab.sv
`timescale 1ns/10ps
`default_nettype none

module nvmpw_ab #(
  parameter int DW = 8,
  parameter int AW = 7
) (
  input  wire logic          core_clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);

  logic [DW-1:0] mem [1<<AW];

  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    rdata <= mem[raddr];
  end

endmodule : nvmpw_ab

`default_nettype wire

//--- nvmpw_flash_model.sv
`timescale 1ns/10ps
`default_nettype none

module nvmpw_flash_model
  import nvmpw_pkg::*;
#(
  parameter int PG_W  = 9,
  parameter int OFF_W = 7
) (
  input  wire logic             core_clk,
  input  wire logic             slow,
  input  wire logic             inj_arm,
  input  wire logic             fl_req,
  input  var  nvmpw_op_e        fl_op,
  input  wire logic [PG_W-1:0]  fl_page,
  input  wire logic [OFF_W-1:0] fl_off,
  input  wire logic [7:0]       fl_wdata,
  output logic                  fl_ack,
  output logic      [7:0]       fl_rdata,
  output logic                  fl_tag_err
);
  logic [7:0] mem [2**PG_W][2**OFF_W];
  logic [7:0] tg  [2**PG_W];
  logic       te  [2**PG_W];
  logic       armed;
  int         erases;
  int         wait_cnt;

  initial begin
    foreach (mem[p, o]) mem[p][o] = ERASED_BYTE;
    foreach (tg[p]) tg[p] = ERASED_BYTE;
    foreach (te[p]) te[p] = 1'b0;
    fl_ack = 1'b0;
    fl_rdata = 8'h00;
    fl_tag_err = 1'b0;
    armed = 1'b0;
    erases = 0;
    wait_cnt = 0;
  end

  // Read lines toggle outside an ack so a stale value never looks valid
  always @(posedge core_clk) begin
    fl_ack <= 1'b0;
    fl_rdata <= ~fl_rdata;
    fl_tag_err <= ~fl_tag_err;
    if (inj_arm) begin
      armed <= 1'b1;
    end
    if (fl_req && !fl_ack && wait_cnt < (slow ? 3 : 0)) begin
      wait_cnt <= wait_cnt + 1;
    end else if (fl_req && !fl_ack) begin
      wait_cnt <= 0;
      fl_ack <= 1'b1;
      case (fl_op)
        OP_READ: fl_rdata <= mem[fl_page][fl_off];
        OP_PROG: begin
          mem[fl_page][fl_off] <= armed ? ~fl_wdata : fl_wdata;
          armed <= 1'b0;
        end
        OP_ERASE: begin
          for (int o = 0; o < 2**OFF_W; o++) mem[fl_page][o] <= ERASED_BYTE;
          tg[fl_page] <= ERASED_BYTE;
          te[fl_page] <= 1'b0;
          erases <= erases + 1;
        end
        OP_RTAG: begin
          fl_rdata <= tg[fl_page];
          fl_tag_err <= te[fl_page];
        end
        OP_WTAG: tg[fl_page] <= fl_wdata;
        default: ;
      endcase
    end
  end
endmodule : nvmpw_flash_model

`default_nettype wire

//--- nvmpw_pkg.sv
package nvmpw_pkg;

  // ------------------------------------------------------------
  // Flash array operations
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ,
    OP_PROG,
    OP_ERASE,
    OP_RTAG,
    OP_WTAG
  } nvmpw_op_e;

  // ------------------------------------------------------------
  // Operation results and map integrity codes
  // ------------------------------------------------------------
  localparam logic [1:0] RES_OK      = 2'h0;
  localparam logic [1:0] RES_PROT    = 2'h1;
  localparam logic [1:0] RES_VERIFY  = 2'h2;
  localparam logic [1:0] RES_NOSPARE = 2'h3;

  localparam logic [1:0] MIS_OK       = 2'h0;
  localparam logic [1:0] MIS_REPAIRED = 2'h1;
  localparam logic [1:0] MIS_BAD      = 2'h2;
  localparam logic [1:0] MIS_BUSY     = 2'h3;

  // ------------------------------------------------------------
  // Data values, tag layout, random source
  // ------------------------------------------------------------
  localparam logic [7:0]  ERASED_BYTE  = 8'hff;
  localparam int          TAG_FREE_BIT = 7;
  localparam logic [15:0] LFSR_SEED    = 16'hace1;
  localparam logic [15:0] LFSR_TAPS    = 16'hb400;
  // About one write in a thousand: 65 / 65536
  localparam logic [15:0] REF_THRESH   = 16'h0041;

endpackage : nvmpw_pkg

//--- nvmpw_seq.sv
`timescale 1ns/10ps
`default_nettype none

module nvmpw_seq
  import nvmpw_pkg::*;
#(
  parameter int PG_W  = 9,
  parameter int DPG_W = 5,
  parameter int OFF_W = 7
) (
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic             req_valid,
  input  wire logic [PG_W-1:0]  req_page,
  input  wire logic             req_retry,
  input  wire logic             merge_valid,
  input  wire logic [OFF_W-1:0] merge_off,
  input  wire logic [7:0]       merge_data,
  input  wire logic             merge_last,
  output logic                  merge_ready,
  output logic                  busy,
  output logic                  done,
  output logic      [1:0]       result,
  input  wire logic             wp_code,
  input  wire logic             wp_data,
  input  wire logic             rd_valid,
  input  wire logic [DPG_W-1:0] rd_page,
  output logic                  rd_done,
  output logic      [DPG_W-1:0] rd_phys,
  output logic                  nmi,
  output logic      [1:0]       map_integrity_status,
  output logic                  fl_req,
  output var nvmpw_op_e         fl_op,
  output logic      [PG_W-1:0]  fl_page,
  output logic      [OFF_W-1:0] fl_off,
  output logic      [7:0]       fl_wdata,
  input  wire logic             fl_ack,
  input  wire logic [7:0]       fl_rdata,
  input  wire logic             fl_tag_err
);

  localparam int NDP = 1 << DPG_W;

  typedef enum logic [4:0] {
    S_RB, S_RP, S_RP_ER, S_SPARE, S_IDLE, S_FILL, S_MERGE, S_ERASE,
    S_PROG, S_TAG, S_VER, S_RETRY, S_MAP, S_ERASE_OLD, S_REF, S_DONE
  } nvmpw_st_e;

  nvmpw_st_e        st;
  logic [1:0]       ph;
  logic [OFF_W-1:0] off;
  logic [PG_W-1:0]  cpage;
  logic [DPG_W-1:0] lp;
  logic [DPG_W-1:0] old_p;
  logic [DPG_W-1:0] spare;
  logic [DPG_W-1:0] scan;
  logic [DPG_W-1:0] cnt;
  logic             is_data;
  logic             mapped_old;
  logic             retry_en;
  logic             retried;
  logic             refreshing;
  logic             blank;
  logic             vfail;
  logic             rb_err;
  logic             dup;
  logic             unrep;
  logic             spare_ok;
  logic             map_ready;
  logic [NDP-1:0]   map_v;
  logic [DPG_W-1:0] map_p [NDP];
  logic [NDP-1:0]   used;
  logic [15:0]      lfsr;
  logic             ab_we;
  logic [OFF_W-1:0] ab_waddr;
  logic [7:0]       ab_wdata;
  logic [7:0]       ab_rdata;
  logic [PG_W-1:0]  prog_pg;
  logic [PG_W-1:0]  scan_pg;
  logic [PG_W-1:0]  old_pg;
  logic [DPG_W-1:0] tag_lp;
  logic             tag_mapped;

  localparam logic [PG_W-DPG_W-1:0] DHI = '1;

  assign scan_pg    = {DHI, scan};
  assign old_pg     = {DHI, old_p};
  assign prog_pg    = is_data ? {DHI, spare} : cpage;
  assign tag_lp     = fl_rdata[DPG_W-1:0];
  assign tag_mapped = ~fl_rdata[TAG_FREE_BIT];

  // ------------------------------------------------------------
  // Assembly buffer
  // ------------------------------------------------------------
  nvmpw_ab #(
    .DW (8),
    .AW (OFF_W)
  ) u_ab (
    .core_clk (core_clk),
    .we       (ab_we),
    .waddr    (ab_waddr),
    .wdata    (ab_wdata),
    .raddr    (off),
    .rdata    (ab_rdata)
  );

  // ------------------------------------------------------------
  // Pseudo-random source
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lfsr <= LFSR_SEED;
    end else begin
      lfsr <= {1'b0, lfsr[15:1]} ^ (lfsr[0] ? LFSR_TAPS : 16'h0000);
    end
  end

  // ------------------------------------------------------------
  // Read translation
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rd_done <= 1'b0;
      rd_phys <= '0;
      nmi     <= 1'b0;
    end else begin
      rd_done <= rd_valid && map_ready;
      nmi     <= rd_valid && map_ready && !map_v[rd_page];
      if (rd_valid) begin
        rd_phys <= map_p[rd_page];
      end
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st <= S_RB;
      ph <= 2'd0;
      off <= '0;
      cpage <= '0;
      lp <= '0;
      old_p <= '0;
      spare <= '0;
      scan <= '0;
      cnt <= '0;
      is_data <= 1'b0;
      mapped_old <= 1'b0;
      retry_en <= 1'b0;
      retried <= 1'b0;
      refreshing <= 1'b0;
      blank <= 1'b1;
      vfail <= 1'b0;
      rb_err <= 1'b0;
      dup <= 1'b0;
      unrep <= 1'b0;
      spare_ok <= 1'b0;
      map_ready <= 1'b0;
      map_v <= '0;
      used <= '0;
      for (int i = 0; i < NDP; i++) begin
        map_p[i] <= '0;
      end
      ab_we <= 1'b0;
      ab_waddr <= '0;
      ab_wdata <= '0;
      merge_ready <= 1'b0;
      busy <= 1'b1;
      done <= 1'b0;
      result <= RES_OK;
      map_integrity_status <= MIS_BUSY;
      fl_req <= 1'b0;
      fl_op <= OP_READ;
      fl_page <= '0;
      fl_off <= '0;
      fl_wdata <= '0;
    end else begin
      ab_we <= 1'b0;
      done <= 1'b0;
      unique case (st)
        // Startup map rebuild from page tags
        S_RB, S_RP: begin
          if (ph == 2'd0) begin
            fl_req <= 1'b1;
            fl_op <= OP_RTAG;
            fl_page <= scan_pg;
            ph <= 2'd1;
          end else if (fl_ack) begin
            fl_req <= 1'b0;
            ph <= 2'd0;
            if (st == S_RB) begin
              if (fl_tag_err) begin
                rb_err <= 1'b1;
                used[scan] <= 1'b1;
              end else if (tag_mapped) begin
                used[scan] <= 1'b1;
                if (map_v[tag_lp]) begin
                  rb_err <= 1'b1;
                end else begin
                  map_v[tag_lp] <= 1'b1;
                  map_p[tag_lp] <= scan;
                end
              end
            end else if (fl_tag_err) begin
              st <= S_RP_ER;
            end else if (tag_mapped) begin
              used[scan] <= 1'b1;
              if (!map_v[tag_lp]) begin
                map_v[tag_lp] <= 1'b1;
                map_p[tag_lp] <= scan;
              end else if (!dup) begin
                dup <= 1'b1;
                st <= S_RP_ER;
              end else begin
                unrep <= 1'b1;
              end
            end
            if (!(st == S_RP && (fl_tag_err || (tag_mapped && map_v[tag_lp] && !dup)))) begin
              scan <= scan + 1'b1;
              if (&scan) begin
                if (st == S_RB && (rb_err || (fl_tag_err || (tag_mapped && map_v[tag_lp])))) begin
                  st <= S_RP;
                  map_v <= '0;
                  used <= '0;
                end else begin
                  map_integrity_status <= (st == S_RB) ? MIS_OK
                                          : (unrep ? MIS_BAD : MIS_REPAIRED);
                  scan <= lfsr[DPG_W-1:0];
                  cnt <= '0;
                  st <= S_SPARE;
                end
              end
            end
          end
        end
        // Faulty or duplicate page erased during repair
        S_RP_ER: begin
          if (ph == 2'd0) begin
            fl_req <= 1'b1;
            fl_op <= OP_ERASE;
            fl_page <= scan_pg;
            ph <= 2'd1;
          end else if (fl_ack) begin
            fl_req <= 1'b0;
            ph <= 2'd0;
            used[scan] <= 1'b0;
            scan <= scan + 1'b1;
            st <= S_RP;
            if (&scan) begin
              map_integrity_status <= unrep ? MIS_BAD : MIS_REPAIRED;
              scan <= lfsr[DPG_W-1:0];
              cnt <= '0;
              st <= S_SPARE;
            end
          end
        end
        // Random erased page becomes the spare
        S_SPARE: begin
          if (!used[scan] || &cnt) begin
            spare <= scan;
            spare_ok <= !used[scan];
            if (!map_ready) begin
              map_ready <= 1'b1;
              busy <= 1'b0;
              st <= S_IDLE;
            end else if (is_data && retry_en && !retried && !refreshing && !used[scan]
                         && lfsr < REF_THRESH) begin
              scan <= lfsr[DPG_W-1:0];
              cnt <= '0;
              st <= S_REF;
            end else begin
              st <= S_DONE;
            end
          end else begin
            scan <= scan + 1'b1;
            cnt <= cnt + 1'b1;
          end
        end
        S_IDLE: begin
          if (req_valid) begin
            is_data <= &req_page[PG_W-1:DPG_W];
            cpage <= req_page;
            lp <= req_page[DPG_W-1:0];
            old_p <= map_p[req_page[DPG_W-1:0]];
            mapped_old <= map_v[req_page[DPG_W-1:0]];
            retry_en <= req_retry;
            retried <= 1'b0;
            refreshing <= 1'b0;
            blank <= 1'b1;
            vfail <= 1'b0;
            off <= '0;
            ph <= 2'd0;
            if (&req_page[PG_W-1:DPG_W] ? wp_data : wp_code) begin
              result <= RES_PROT;
              done <= 1'b1;
            end else if (&req_page[PG_W-1:DPG_W] && !spare_ok) begin
              result <= RES_NOSPARE;
              done <= 1'b1;
            end else begin
              result <= RES_OK;
              busy <= 1'b1;
              st <= S_FILL;
            end
          end
        end
        // Buffer preset or copy of the current page
        S_FILL: begin
          if (is_data && !mapped_old) begin
            ab_we <= 1'b1;
            ab_waddr <= off;
            ab_wdata <= ERASED_BYTE;
            off <= off + 1'b1;
            if (&off) begin
              merge_ready <= !refreshing;
              st <= S_MERGE;
            end
          end else if (ph == 2'd0) begin
            fl_req <= 1'b1;
            fl_op <= OP_READ;
            fl_page <= is_data ? old_pg : cpage;
            fl_off <= off;
            ph <= 2'd1;
          end else if (fl_ack) begin
            fl_req <= 1'b0;
            ph <= 2'd0;
            ab_we <= 1'b1;
            ab_waddr <= off;
            ab_wdata <= fl_rdata;
            blank <= blank && (fl_rdata == ERASED_BYTE);
            off <= off + 1'b1;
            if (&off) begin
              merge_ready <= !refreshing;
              st <= S_MERGE;
            end
          end
        end
        // Caller bytes merged into the buffer
        S_MERGE: begin
          if (refreshing || (merge_valid && merge_last)) begin
            merge_ready <= 1'b0;
            st <= (is_data || blank) ? S_PROG : S_ERASE;
          end
          if (merge_valid && !refreshing) begin
            ab_we <= 1'b1;
            ab_waddr <= merge_off;
            ab_wdata <= merge_data;
          end
        end
        S_ERASE, S_RETRY, S_ERASE_OLD: begin
          if (ph == 2'd0) begin
            fl_req <= 1'b1;
            fl_op <= OP_ERASE;
            fl_page <= (st == S_ERASE_OLD) ? old_pg : prog_pg;
            ph <= 2'd1;
          end else if (fl_ack) begin
            fl_req <= 1'b0;
            ph <= 2'd0;
            off <= '0;
            vfail <= 1'b0;
            st <= S_PROG;
            if (st == S_ERASE_OLD) begin
              used[old_p] <= 1'b0;
              scan <= lfsr[DPG_W-1:0];
              cnt <= '0;
              st <= S_SPARE;
            end
          end
        end
        // Byte program and read-back verify
        S_PROG, S_VER: begin
          if (ph == 2'd0) begin
            // Let a merged byte land before the buffer read
            if (!ab_we) begin
              ph <= 2'd1;
            end
          end else if (ph == 2'd1) begin
            fl_req <= 1'b1;
            fl_op <= (st == S_PROG) ? OP_PROG : OP_READ;
            fl_page <= prog_pg;
            fl_off <= off;
            fl_wdata <= ab_rdata;
            ph <= 2'd2;
          end else if (fl_ack) begin
            fl_req <= 1'b0;
            ph <= 2'd0;
            off <= off + 1'b1;
            if (st == S_VER && fl_rdata != ab_rdata) begin
              vfail <= 1'b1;
            end
            if (&off) begin
              if (st == S_PROG) begin
                st <= is_data ? S_TAG : S_VER;
              end else if ((vfail || fl_rdata != ab_rdata) && retry_en && !retried && !refreshing) begin
                retried <= 1'b1;
                st <= S_RETRY;
              end else begin
                if (vfail || fl_rdata != ab_rdata) begin
                  result <= RES_VERIFY;
                end
                st <= is_data ? S_MAP : S_DONE;
              end
            end
          end
        end
        S_TAG: begin
          if (ph == 2'd0) begin
            fl_req <= 1'b1;
            fl_op <= OP_WTAG;
            fl_page <= prog_pg;
            fl_wdata <= {1'b0, {(7-DPG_W){1'b0}}, lp};
            ph <= 2'd1;
          end else if (fl_ack) begin
            fl_req <= 1'b0;
            ph <= 2'd0;
            st <= S_VER;
          end
        end
        S_MAP: begin
          map_v[lp] <= 1'b1;
          map_p[lp] <= spare;
          used[spare] <= 1'b1;
          if (mapped_old) begin
            st <= S_ERASE_OLD;
          end else begin
            scan <= lfsr[DPG_W-1:0];
            cnt <= '0;
            st <= S_SPARE;
          end
        end
        // Disturb refresh of another used page
        S_REF: begin
          if (map_v[scan] && scan != lp) begin
            lp <= scan;
            old_p <= map_p[scan];
            mapped_old <= 1'b1;
            refreshing <= 1'b1;
            off <= '0;
            ph <= 2'd0;
            st <= S_FILL;
          end else if (&cnt) begin
            st <= S_DONE;
          end else begin
            scan <= scan + 1'b1;
            cnt <= cnt + 1'b1;
          end
        end
        S_DONE: begin
          done <= 1'b1;
          busy <= 1'b0;
          st <= S_IDLE;
        end
      endcase
    end
  end

endmodule : nvmpw_seq

`default_nettype wire

//--- nvmpw_seq_asserts.sv
`timescale 1ns/10ps
`default_nettype none

module nvmpw_seq_asserts
  import nvmpw_pkg::*;
#(
  parameter int PG_W  = 9,
  parameter int OFF_W = 7
) (
  input wire logic             core_clk,
  input wire logic             rstn,
  input wire logic             req_valid,
  input wire logic             wp_code,
  input wire logic             wp_data,
  input wire logic             merge_ready,
  input wire logic             busy,
  input wire logic             done,
  input wire logic [1:0]       result,
  input wire logic             rd_valid,
  input wire logic             rd_done,
  input wire logic             nmi,
  input wire logic [1:0]       map_integrity_status,
  input wire logic             fl_req,
  input var  nvmpw_op_e        fl_op,
  input wire logic [PG_W-1:0]  fl_page,
  input wire logic [OFF_W-1:0] fl_off,
  input wire logic             fl_ack
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  a_done_pulse: assert property (done |=> !done)
    else $error("done pulse longer than one cycle");
  a_done_idle: assert property (done |-> !busy)
    else $error("busy still high with done");
  a_merge_busy: assert property (merge_ready |-> busy)
    else $error("merge window open while idle");
  a_flash_idle: assert property (!busy |-> !fl_req)
    else $error("flash request while idle");
  a_flash_hold: assert property (fl_req && !fl_ack |=> fl_req && $stable(fl_op) && $stable(fl_page) && $stable(fl_off))
    else $error("flash request changed before ack");
  a_flash_drop: assert property (fl_req && fl_ack |=> !fl_req)
    else $error("flash request kept after ack");
  a_prot_refuse: assert property (req_valid && !busy && wp_code && wp_data |=> done && !busy && result == RES_PROT)
    else $error("protected request not refused");
  a_read_answer: assert property (rd_valid && map_integrity_status != MIS_BUSY |=> rd_done)
    else $error("read translation not answered");
  a_nmi_read: assert property (nmi |-> rd_done)
    else $error("nmi without read answer");

  c_verify_fail: cover property (done && result == RES_VERIFY);
  c_nmi: cover property (nmi);
  c_map_bad: cover property ($fell(busy) && map_integrity_status == MIS_BAD);
endmodule : nvmpw_seq_asserts

bind nvmpw_seq nvmpw_seq_asserts #(.PG_W(PG_W), .OFF_W(OFF_W)) chk (
  .core_clk, .rstn, .req_valid, .wp_code, .wp_data, .merge_ready, .busy, .done, .result, .rd_valid,
  .rd_done, .nmi, .map_integrity_status, .fl_req, .fl_op, .fl_page, .fl_off, .fl_ack
);

`default_nettype wire

//--- nvmpw_seq_test.sv
`timescale 1ns/10ps
`default_nettype none

module nvmpw_seq_test
  import nvmpw_pkg::*;
;
  logic       core_clk = 1'b0, rstn = 1'b0, req_valid = 1'b0, req_retry = 1'b0;
  logic       merge_valid = 1'b0, merge_last = 1'b0, wp_code = 1'b0, wp_data = 1'b0;
  logic       rd_valid = 1'b0, slow = 1'b0, inj_arm = 1'b0;
  logic [8:0] req_page = 9'h000;
  logic [6:0] merge_off = 7'h00;
  logic [7:0] merge_data = 8'h00;
  logic [4:0] rd_page = 5'h00, q;
  logic       merge_ready, busy, done, rd_done, nmi, fl_req, fl_ack, fl_tag_err;
  logic [1:0] result, map_integrity_status;
  logic [4:0] rd_phys;
  logic [8:0] fl_page;
  logic [6:0] fl_off;
  logic [7:0] fl_wdata, fl_rdata;
  nvmpw_op_e  fl_op;
  int         bad_count = 0;
  int         checks = 0;

  always #25 core_clk = ~core_clk;

  nvmpw_seq uut (
    .core_clk, .rstn, .req_valid, .req_page, .req_retry, .merge_valid, .merge_off, .merge_data, .merge_last,
    .merge_ready, .busy, .done, .result, .wp_code, .wp_data, .rd_valid, .rd_page, .rd_done, .rd_phys, .nmi,
    .map_integrity_status, .fl_req, .fl_op, .fl_page, .fl_off, .fl_wdata, .fl_ack, .fl_rdata, .fl_tag_err
  );

  nvmpw_flash_model flm (
    .core_clk, .slow, .inj_arm, .fl_req, .fl_op, .fl_page, .fl_off, .fl_wdata, .fl_ack, .fl_rdata, .fl_tag_err
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic cmp(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : cmp

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic rst(input logic [1:0] exp);
    int n = 0;
    rstn <= 1'b0;
    repeat (6) @(posedge core_clk);
    cmp(busy, 1'b1, "busy in reset");
    cmp(map_integrity_status, MIS_BUSY, "status in reset");
    rstn <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (busy !== 1'b0 && n < 4000);
    cmp(map_integrity_status, exp, "integrity status");
    cmp(busy, 1'b0, "busy after rebuild");
  endtask : rst

  task automatic wr(input logic [8:0] pg, input logic rt, input logic [6:0] off, input logic [7:0] d,
                    input logic [1:0] exp);
    int   n = 0;
    logic sent = 1'b0;
    req_valid <= 1'b1;
    req_page <= pg;
    req_retry <= rt;
    merge_off <= off;
    merge_data <= d;
    @(posedge core_clk);
    req_valid <= 1'b0;
    // Next request only after done
    do begin
      @(posedge core_clk);
      merge_valid <= merge_ready && !sent;
      merge_last <= merge_ready && !sent;
      sent = sent | merge_ready;
      n++;
    end while (done !== 1'b1 && n < 9000);
    cmp(done, 1'b1, "done");
    cmp(result, exp, "result");
  endtask : wr

  task automatic rd(input logic [4:0] lp, input logic nmi_exp, output logic [4:0] ph);
    rd_valid <= 1'b1;
    rd_page <= lp;
    @(posedge core_clk);
    rd_valid <= 1'b0;
    @(posedge core_clk);
    cmp(rd_done, 1'b1, "rd_done");
    cmp(nmi, nmi_exp, "nmi");
    ph = rd_phys;
  endtask : rd

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_code();
    int e = flm.erases;
    wr(9'h010, 1'b0, 7'h00, 8'h3c, RES_OK);
    cmp(flm.mem[16][0], 8'h3c, "merged byte");
    cmp(flm.mem[16][6], ERASED_BYTE, "preset byte");
    cmp(flm.erases, e, "erase count");
    wr(9'h010, 1'b0, 7'h09, 8'ha5, RES_OK);
    cmp(flm.mem[16][0], 8'h3c, "copied byte");
    cmp(flm.mem[16][9], 8'ha5, "new byte");
    cmp(flm.erases, e + 1, "erase count");
  endtask : t_code

  task automatic t_prot();
    wp_code <= 1'b1;
    wp_data <= 1'b1;
    wr(9'h020, 1'b0, 7'h00, 8'h00, RES_PROT);
    wp_code <= 1'b0;
    wr(9'h1e7, 1'b0, 7'h00, 8'h00, RES_PROT);
    wp_data <= 1'b0;
    cmp(flm.mem[32][0], ERASED_BYTE, "protected page");
  endtask : t_prot

  task automatic t_retry();
    int e = flm.erases;
    inj_arm <= 1'b1;
    @(posedge core_clk);
    inj_arm <= 1'b0;
    wr(9'h030, 1'b1, 7'h01, 8'h5a, RES_OK);
    cmp(flm.mem[48][1], 8'h5a, "retried byte");
    cmp(flm.erases, e + 1, "retry erase");
    inj_arm <= 1'b1;
    @(posedge core_clk);
    inj_arm <= 1'b0;
    wr(9'h031, 1'b0, 7'h01, 8'h5a, RES_VERIFY);
  endtask : t_retry

  task automatic t_data(output logic [4:0] q);
    logic [4:0] p;
    slow <= 1'b1;
    wr(9'h1e3, 1'b0, 7'h02, 8'h11, RES_OK);
    rd(5'h03, 1'b0, p);
    cmp(flm.tg[{4'hf, p}], 8'h03, "map tag");
    cmp(flm.mem[{4'hf, p}][2], 8'h11, "spare byte");
    cmp(flm.mem[{4'hf, p}][3], ERASED_BYTE, "spare preset");
    rd(5'h04, 1'b1, q);
    wr(9'h1e3, 1'b0, 7'h04, 8'h22, RES_OK);
    rd(5'h03, 1'b0, q);
    cmp(q == p, 1'b0, "new physical page");
    cmp(flm.mem[{4'hf, q}][2], 8'h11, "copied byte");
    cmp(flm.mem[{4'hf, q}][4], 8'h22, "merged byte");
    cmp(flm.tg[{4'hf, p}], ERASED_BYTE, "old page erased");
    cmp(map_integrity_status, MIS_OK, "no repair at run time");
    slow <= 1'b0;
  endtask : t_data

  task automatic t_rebuild(input logic [4:0] q);
    flm.te[{4'hf, ~q}] = 1'b1;
    rst(MIS_REPAIRED);
    flm.tg[{4'hf, ~q}] = 8'h03;
    rst(MIS_REPAIRED);
    flm.tg[{4'hf, ~q}] = 8'h03;
    flm.tg[{4'hf, q ^ 5'h01}] = 8'h03;
    flm.tg[{4'hf, q ^ 5'h02}] = 8'h03;
    rst(MIS_BAD);
    // No data writes follow while the map is bad
  endtask : t_rebuild

  initial begin
    rst(MIS_OK);
    t_code();
    t_prot();
    t_retry();
    t_data(q);
    t_rebuild(q);
    conclude();
  end

  initial begin
    repeat (80000) @(posedge core_clk);
    bad_count++;
    conclude();
  end
endmodule : nvmpw_seq_test

`default_nettype wire
